// File: ppl_lookup.sv
// Pixel lookup path with palette, overlays and output FIFO
`timescale 1ns/100ps
`include "ppl_consts.svh"

module ppl_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data = mem[rd_r];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wr_r <= wr_r + 1'b1;
            if (pop) rd_r <= rd_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_bound: assert property (@(posedge clk)
        disable iff (!reset_n) cnt_r <= (AW+1)'(DEPTH))
        else $error("fifo count past its depth");
endmodule

module ppl_lookup #(
    parameter int ENTRIES = `PPL_ENTRIES,
    parameter int FIFO_DEPTH = `PPL_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Frame buffer side
    input wire logic [7:0] pixel_index,
    input wire logic overlay_select_lo,
    input wire logic overlay_select_hi,
    input wire logic sync_n,
    input wire logic blank_n,
    input wire logic cs_n,
    // Table load port
    input wire logic tbl_we,
    input wire logic [7:0] tbl_addr,
    input wire logic tbl_ovl,
    input wire ppl_pkg::ppl_rgb_t tbl_data,
    // Converter side
    input wire logic dac_ready,
    output logic in_ready,
    output logic out_valid,
    output logic [7:0] red_current_out,
    output logic [7:0] green_current_out,
    output logic [7:0] blue_current_out,
    output logic sync_current_out,
    output logic blank_out_n
);
    ppl_pkg::ppl_rgb_t palette [ENTRIES];
    ppl_pkg::ppl_rgb_t overlay_r [1:3];
    ppl_pkg::ppl_pix_t cap_r;
    ppl_pkg::ppl_out_t look_r;
    ppl_pkg::ppl_out_t look_nxt;
    logic cap_v_r;
    logic look_v_r;
    ppl_pkg::ppl_out_t fifo_q;
    logic fifo_v;
    logic fifo_rdy;
    logic stall;

    always_ff @(posedge clk) begin
        if (tbl_we && !tbl_ovl) palette[tbl_addr] <= tbl_data;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overlay_r[1] <= '0;
            overlay_r[2] <= '0;
            overlay_r[3] <= '0;
        end else if (tbl_we && tbl_ovl && tbl_addr[1:0] != 2'h0) begin
            overlay_r[tbl_addr[1:0]] <= tbl_data;
        end
    end

    assign stall = !fifo_rdy;
    // sync and blank ride the same stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_r <= '0;
            cap_v_r <= 1'b0;
        end else if (!stall) begin
            cap_r <= '{pixel_index, {overlay_select_hi, overlay_select_lo},
                       sync_n, blank_n, cs_n};
            cap_v_r <= 1'b1;
        end
    end

    wire [1:0] ovl_sel = cap_r.overlay;
    wire ppl_pkg::ppl_rgb_t pal_q = palette[cap_r.index];
    // pixel inputs disregarded under chip select
    wire ppl_pkg::ppl_rgb_t col_sel = cap_r.cs_n == 1'b0 ? '0 :
        (ovl_sel == `PPL_OVL_NONE ? pal_q : overlay_r[ovl_sel]);
    // blank forces black code; chip select forces black
    wire force_blk = !cap_r.blank_n || !cap_r.cs_n;
    always_comb begin
        look_nxt.code = force_blk ? {3{`PPL_CODE_BLACK}} : col_sel;
        // sync only drives the separate sync current
        look_nxt.sync_on = cap_r.sync_n;
        look_nxt.blank_n = cap_r.blank_n;
    end
    // one fixed lookup stage for all fields
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            look_r <= '0;
            look_v_r <= 1'b0;
        end else if (!stall) begin
            look_r <= look_nxt;
            look_v_r <= cap_v_r;
        end
    end

    ppl_fifo #(.WIDTH($bits(ppl_pkg::ppl_out_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(look_v_r && !stall),
        .in_ready(fifo_rdy),
        .in_data(look_r),
        .out_valid(fifo_v),
        .out_ready(dac_ready),
        .out_data(fifo_q)
    );

    // 24-bit entry split into three channels
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            red_current_out <= `PPL_CODE_BLACK;
            green_current_out <= `PPL_CODE_BLACK;
            blue_current_out <= `PPL_CODE_BLACK;
            sync_current_out <= 1'b0;
            blank_out_n <= 1'b0;
            out_valid <= 1'b0;
            in_ready <= 1'b0;
        end else begin
            out_valid <= fifo_v && dac_ready;
            in_ready <= fifo_rdy;
            if (fifo_v && dac_ready) begin
                red_current_out <= fifo_q.code.red;
                green_current_out <= fifo_q.code.green;
                blue_current_out <= fifo_q.code.blue;
                sync_current_out <= fifo_q.sync_on;
                blank_out_n <= fifo_q.blank_n;
            end
        end
    end

    // Two free edges carry one pixel from the pins into the lookup stage
    sequence s_two_moves;
        (reset_n && !stall) ##1 !stall;
    endsequence

    a_cs_black: assert property (@(posedge clk)
        disable iff (!reset_n)
        (cap_r.cs_n == 1'b0 && !stall) |=> look_r.code == '0)
        else $error("chip select did not force black");

    a_blank_black: assert property (@(posedge clk)
        disable iff (!reset_n)
        (!cap_r.blank_n && !stall) |=> look_r.code == '0)
        else $error("blank did not force black");

    a_sync_align: assert property (@(posedge clk)
        disable iff (!reset_n)
        s_two_moves |=> look_r.sync_on == $past(sync_n, 2))
        else $error("sync misaligned");

    a_overlay_pick: assert property (@(posedge clk)
        disable iff (!reset_n)
        (cap_r.cs_n && cap_r.blank_n && ovl_sel != 2'h0 && !stall
         && !tbl_we) |=> look_r.code == $past(overlay_r[ovl_sel]))
        else $error("overlay color wrong");

    a_palette_pick: assert property (@(posedge clk)
        disable iff (!reset_n)
        (cap_r.cs_n && cap_r.blank_n && ovl_sel == `PPL_OVL_NONE && !stall)
        |=> look_r.code == $past(palette[cap_r.index]))
        else $error("palette entry wrong");

    a_sync_code: assert property (@(posedge clk)
        disable iff (!reset_n)
        (!cap_r.sync_n && cap_r.blank_n && cap_r.cs_n && !stall)
        |=> look_r.code == $past(col_sel))
        else $error("sync changed the color code");

    a_stall_hold: assert property (@(posedge clk)
        disable iff (!reset_n)
        stall |=> $stable(cap_r) && $stable(look_r))
        else $error("pipeline moved while stalled");

    a_out_hold: assert property (@(posedge clk)
        disable iff (!reset_n)
        !out_valid |-> $stable({red_current_out, green_current_out,
            blue_current_out, sync_current_out, blank_out_n}))
        else $error("outputs moved without a sample");
endmodule

// File: ppl_consts.svh
// Constants for the palette pixel lookup port
// Behaviour
// - Pixel index and overlay select captured every rising clock edge on which the FIFO is not full.
// - Overlay select zero: pixel index picks one of 256 palette entries.
// - Overlay select 1, 2, 3 picks overlay color; pixel index ignored.
// - Each entry gives 24 bits: 8 red, 8 green, 8 blue.
// - Sync and blank captured on the same edge as the pixel inputs.
// - Unblanked codes come from color data; FFH white, 00H black.
// - Blank low forces blank level; sync low too gives sync level.
// - Sync only affects the separate sync current, not red or blue.
// - Chip select low makes pixel and overlay inputs disregarded.
// - Chip select low forces all video outputs to black; the code blacks only red, green and blue, not sync or blank.
`ifndef PPL_CONSTS_SVH
`define PPL_CONSTS_SVH
`define PPL_ENTRIES 256
`define PPL_CODE_BLACK 8'h00
`define PPL_CODE_WHITE 8'hFF
`define PPL_OVL_NONE 2'h0
`define PPL_FIFO_DEPTH 32
`endif

// File: ppl_pkg.sv
// Types for the palette pixel lookup port
package ppl_pkg;
    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } ppl_rgb_t;
    typedef struct packed {
        logic [7:0] index;
        logic [1:0] overlay;
        logic sync_n;
        logic blank_n;
        logic cs_n;
    } ppl_pix_t;
    typedef struct packed {
        ppl_rgb_t code;
        logic sync_on;
        logic blank_n;
    } ppl_out_t;
endpackage

// File: ppl_dac_model.sv
// Converter-side partner that accepts samples or stalls on command
`timescale 1ns/100ps
module ppl_dac_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control from the bench
    input wire logic stall,
    // Converter handshake
    output logic dac_ready
);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) dac_ready <= 1'b0;
        else dac_ready <= !stall;
    end
endmodule

// File: ppl_lookup_bench.sv
// Self-checking bench for the pixel lookup path
`timescale 1ns/100ps
module ppl_lookup_bench;
    logic clk = 0, reset_n = 0, stall = 1, tbl_we = 0, tbl_ovl = 0;
    // Chip select starts low so outputs stay black until tables are loaded
    logic ol_lo = 0, ol_hi = 0, sync_n = 1, blank_n = 1, cs_n = 0;
    logic [7:0] pixel_index = 0, tbl_addr = 0, red, green, blue;
    logic dac_ready, in_ready, out_valid, sync_out, blank_out_n;
    wire ppl_pkg::ppl_rgb_t rgb = {red, green, blue};
    ppl_pkg::ppl_rgb_t tbl_data = 0, d, pal[256], ovl[4];
    ppl_pkg::ppl_pix_t q[$], cur, got, seen;
    int miscompares = 0, checked = 0, n;
    always #10 clk = ~clk;
    ppl_dac_model i_dac (.clk(clk), .reset_n(reset_n), .stall(stall),
        .dac_ready(dac_ready));
    ppl_lookup i_dut (.clk(clk), .reset_n(reset_n), .pixel_index(pixel_index),
        .overlay_select_lo(ol_lo), .overlay_select_hi(ol_hi),
        .sync_n(sync_n), .blank_n(blank_n), .cs_n(cs_n), .tbl_we(tbl_we),
        .tbl_addr(tbl_addr), .tbl_ovl(tbl_ovl), .tbl_data(tbl_data),
        .dac_ready(dac_ready), .in_ready(in_ready), .out_valid(out_valid),
        .red_current_out(red), .green_current_out(green),
        .blue_current_out(blue), .sync_current_out(sync_out),
        .blank_out_n(blank_out_n));
    function automatic ppl_pkg::ppl_rgb_t exp_rgb(ppl_pkg::ppl_pix_t p);
        if (!p.cs_n || !p.blank_n) return 24'h0000_00;
        if (p.overlay != 2'h0) return ovl[p.overlay];
        return pal[p.index];
    endfunction
    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic drv(ppl_pkg::ppl_pix_t p);
        @(posedge clk);
        pixel_index <= p.index;
        {ol_hi, ol_lo} <= p.overlay;
        {sync_n, blank_n, cs_n} <= {p.sync_n, p.blank_n, p.cs_n};
    endtask
    // Check each shown sample, then queue the pixel the last edge kept;
    // in_ready lags the capture decision by one edge
    always @(posedge clk) begin
        if (out_valid === 1'b1) begin
            checked++;
            if (q.size() == 0) begin
                miscompares++;
                $display("MISMATCH %0t sample without a pixel", $time);
            end else begin
                got = q.pop_front();
                if (rgb !== exp_rgb(got)) begin
                    miscompares++;
                    $display("MISMATCH %0t color of pixel %h", $time,
                        got.index);
                end
                if (sync_out !== got.sync_n) begin
                    miscompares++;
                    $display("MISMATCH %0t sync current", $time);
                end
                if (blank_out_n !== got.blank_n) begin
                    miscompares++;
                    $display("MISMATCH %0t blank level", $time);
                end
            end
        end
        if (in_ready === 1'b1) q.push_back(seen);
        seen = {pixel_index, ol_hi, ol_lo, sync_n, blank_n, cs_n};
    end
    initial begin
        void'($urandom(66980));
        repeat (6) @(posedge clk);
        reset_n <= 1;
        stall <= 0;
        // Load palette and overlays while chip select holds outputs black
        for (int i = 1; i < 260; i++) begin
            @(posedge clk);
            d = 24'($urandom);
            tbl_we <= 1;
            tbl_ovl <= (i > 256);
            tbl_addr <= (i > 256) ? 8'(i - 256) : 8'(i - 1);
            tbl_data <= d;
            if (i > 256) ovl[i - 256] = d;
            else pal[i - 1] = d;
        end
        @(posedge clk);
        tbl_we <= 0;
        // Random pixels, palette edges 00 and FF shown first
        for (int i = 0; i < 600; i++) begin
            cur.index = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            cur.overlay = (i < 2 || $urandom % 3) ? 2'h0 : 2'($urandom);
            cur.sync_n = 1'($urandom);
            cur.blank_n = (i < 2 || $urandom % 8 != 0);
            cur.cs_n = (i < 2 || $urandom % 8 != 0);
            drv(cur);
        end
        // Fill the FIFO with one held pixel until it refuses, then drain
        cur.cs_n = 1;
        cur.blank_n = 1;
        cur.overlay = 2'h3;
        drv(cur);
        stall <= 1;
        n = 0;
        while (in_ready !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin
            miscompares++;
            $display("MISMATCH %0t FIFO never refused", $time);
        end else begin
            stall <= 0;
            n = checked;
            repeat (60) @(posedge clk);
            if (checked - n < 50) begin
                miscompares++;
                $display("MISMATCH %0t drain stalled", $time);
            end
        end
        // More in flight than FIFO plus stages means pixels went missing
        if (q.size() > 40) begin
            miscompares++;
            $display("MISMATCH %0t %0d pixels never shown", $time,
                q.size());
        end
        complete_run();
    end
endmodule
